// >>> logic/hsac_top.sv
// Contract
// (R1) Concatenate arguments, pad to one 64-byte block.
// (R2) Every digest comes from one block.
// (R3) Derived secret hashes common secret, ID, diversifier.
// (R4) Internal random source seeds authentication challenge.
// (R5) Accept commands 60ms after power and reset; the code waits 1000ms instead while the penalty pin is high.
// (R6) Reset low clears every internal state; the nonvolatile key, secret, password and counter stores keep theirs.
// (R7) Sleep high ignores all bus transitions.
// (R8) No bus transition accepted 50ms after wake.
// (R9) Sixteen stored host keys of 64 bits.
// (R10) Eight sets of two 24-bit passwords.
// (R11) Four up-only counters, ceiling 6.4 million.
// (R12) Bus slave only; never holds clock low.
// (R13) Host waits for readiness before commanding.
`timescale 1ns/1ps
module hsac_top import hsac_pkg::*; #(
  parameter int BOOT_CYC = BOOT_READY_CYC,
  parameter int WAKE_CYC = WAKE_HOLD_CYC,
  parameter int PENALTY_CYC = PENALTY_READY_CYC
) (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // Pins from the board.
  input wire logic i_supply_good,
  input wire logic i_penalty_active,
  input wire logic i_sleep_request_pin,
  // Two-wire bus, device side.
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe_n,
  output logic o_scl_out,
  output logic o_scl_oe_n,
  output logic [7:0] o_bus_byte,
  output logic o_bus_byte_valid,
  // Decoded command port.
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_op,
  input wire logic [3:0] i_cmd_index,
  input wire logic [FIELD_BITS-1:0] i_cmd_data,
  input wire logic [FIELD_BITS-1:0] i_cmd_id,
  input wire logic [FIELD_BITS-1:0] i_cmd_div,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic o_rsp_flag,
  output logic [DIGEST_BITS-1:0] o_rsp_data,
  output logic o_accepting
);
  logic [4:0] sync1_reg, sync2_reg;
  logic [1:0] bus_d_reg;
  logic supply_s, penalty_s, sleep_s, scl_s, sda_s;
  hsac_pwr_t pwr_reg, pwr_next;
  logic [31:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shift_reg, shift_next, byte_reg, byte_next;
  logic frame_reg, frame_next, ack_reg, ack_next, bval_reg, bval_next;
  logic [63:0] lfsr_reg, lfsr_next;
  logic rsp_v_reg, rsp_v_next, rsp_f_reg, rsp_f_next, wait_reg, wait_next;
  logic [DIGEST_BITS-1:0] rsp_d_reg, rsp_d_next;
  logic [FIELD_BITS-1:0] key_mem [KEY_COUNT];
  logic [FIELD_BITS-1:0] secret_mem [SECRET_COUNT];
  logic [PWD_BITS-1:0] pwd_mem [PWD_SETS][2];
  // Counters leave the factory erased to zero.
  logic [CTR_BITS-1:0] ctr_mem [CTR_COUNT] = '{default: '0};
  logic take, sha_start, sha_busy, sha_done, ctr_we, bus_open;
  logic [DIGEST_BITS-1:0] sha_digest;
  logic [BLOCK_BITS-1:0] block;
  logic [CTR_BITS-1:0] ctr_old, ctr_new;
  logic [31:0] boot_limit;

  // Pins cross into the clock domain through two flops each.
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      bus_d_reg <= 2'h3;
    end
    else
    begin
      sync1_reg <= {i_supply_good, i_penalty_active, i_sleep_request_pin,
        i_scl, i_sda};
      sync2_reg <= sync1_reg;
      bus_d_reg <= sync2_reg[1:0];
    end
  end
  assign {supply_s, penalty_s, sleep_s, scl_s, sda_s} = sync2_reg;

  // Readiness sequencing after reset, power and sleep.
  assign boot_limit = penalty_s ? PENALTY_CYC : BOOT_CYC;
  always_comb
  begin
    pwr_next = pwr_reg;
    cnt_next = cnt_reg + 32'h1;
    case (pwr_reg)
      ST_BOOT:
      begin
        if (!supply_s)
          cnt_next = 32'h0;
        else if (cnt_reg >= boot_limit - 1) // R5
          pwr_next = ST_READY;
      end
      ST_SLEEP:
      begin
        cnt_next = 32'h0;
        if (!sleep_s)
          pwr_next = ST_WAKE;
      end
      ST_WAKE:
      begin
        if (cnt_reg >= WAKE_CYC - 1) // R8
          pwr_next = ST_READY;
      end
      ST_READY: cnt_next = 32'h0;
      default: pwr_next = ST_BOOT;
    endcase
    if (sleep_s) // R7
    begin
      pwr_next = ST_SLEEP;
      cnt_next = 32'h0;
    end
    if (!supply_s && pwr_reg != ST_BOOT)
    begin
      pwr_next = ST_BOOT;
      cnt_next = 32'h0;
    end
  end
  assign bus_open = (pwr_reg == ST_READY);

  // Byte receiver; it acknowledges but never touches the clock line.
  always_comb
  begin
    bit_next = bit_reg;
    shift_next = shift_reg;
    byte_next = byte_reg;
    frame_next = frame_reg;
    ack_next = ack_reg;
    bval_next = 1'b0;
    if (!bus_open || sleep_s) // R7 R8
    begin
      bit_next = 4'h0;
      frame_next = 1'b0;
      ack_next = 1'b0;
    end
    else if (scl_s && bus_d_reg[1] && bus_d_reg[0] != sda_s)
    begin
      frame_next = !sda_s;
      bit_next = 4'h0;
      ack_next = 1'b0;
    end
    else if (frame_reg && scl_s && !bus_d_reg[1] && bit_reg < 4'h8)
    begin
      shift_next = {shift_reg[6:0], sda_s};
      bit_next = bit_reg + 4'h1;
      if (bit_reg == 4'h7)
      begin
        byte_next = {shift_reg[6:0], sda_s};
        bval_next = 1'b1;
      end
    end
    else if (frame_reg && !scl_s && bus_d_reg[1])
    begin
      if (ack_reg)
      begin
        ack_next = 1'b0;
        bit_next = 4'h0;
      end
      else if (bit_reg == 4'h8)
        ack_next = 1'b1;
    end
  end

  // Commands, hashing and the random source.
  assign take = i_cmd_valid && o_cmd_ready;
  assign sha_start = take && i_cmd_op == OP_DERIVE;
  assign block = {secret_mem[i_cmd_index[1:0]], i_cmd_id, i_cmd_div, // R3
    PAD_MARK, 248'h0, MSG_LEN_BITS}; // R1
  assign ctr_old = ctr_mem[i_cmd_index[1:0]];
  assign ctr_new = (ctr_old < CTR_MAX) ? ctr_old + 23'h000001 : ctr_old;
  assign ctr_we = take && i_cmd_op == OP_COUNT;
  always_comb
  begin
    lfsr_next = {lfsr_reg[62:0],
      lfsr_reg[63] ^ lfsr_reg[62] ^ lfsr_reg[60] ^ lfsr_reg[59]};
    rsp_v_next = 1'b0;
    rsp_f_next = rsp_f_reg;
    rsp_d_next = rsp_d_reg;
    wait_next = wait_reg;
    if (wait_reg && sha_done)
    begin
      wait_next = 1'b0;
      rsp_v_next = 1'b1;
      rsp_f_next = 1'b0;
      rsp_d_next = sha_digest;
    end
    else if (take)
    begin
      rsp_v_next = (i_cmd_op != OP_DERIVE);
      rsp_f_next = 1'b0;
      rsp_d_next = '0;
      case (i_cmd_op)
        OP_DERIVE: wait_next = 1'b1;
        OP_CHALLENGE: rsp_d_next[63:0] = lfsr_reg; // R4
        OP_CHECK_PWD:
          rsp_f_next = pwd_mem[i_cmd_index[2:0]][i_cmd_index[3]] ==
            i_cmd_data[PWD_BITS-1:0];
        OP_COUNT:
        begin
          rsp_f_next = (ctr_old == CTR_MAX);
          rsp_d_next[CTR_BITS-1:0] = ctr_new;
        end
        default: rsp_f_next = 1'b0;
      endcase
    end
  end

  // Nonvolatile stores keep their contents across reset.
  always_ff @(posedge i_ref_clk)
  begin
    if (take && i_cmd_op == OP_SET_KEY)
      key_mem[i_cmd_index] <= i_cmd_data; // R9
    if (take && i_cmd_op == OP_SET_SECRET)
      secret_mem[i_cmd_index[1:0]] <= i_cmd_data;
    if (take && i_cmd_op == OP_SET_PWD)
      pwd_mem[i_cmd_index[2:0]][i_cmd_index[3]] <=
        i_cmd_data[PWD_BITS-1:0]; // R10
    if (ctr_we)
      ctr_mem[i_cmd_index[1:0]] <= ctr_new; // R11
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn) // R6
    begin
      pwr_reg <= ST_BOOT;
      cnt_reg <= 32'h0;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_reg <= 8'h00;
      frame_reg <= 1'b0;
      ack_reg <= 1'b0;
      bval_reg <= 1'b0;
      lfsr_reg <= LFSR_SEED;
      rsp_v_reg <= 1'b0;
      rsp_f_reg <= 1'b0;
      rsp_d_reg <= '0;
      wait_reg <= 1'b0;
    end
    else
    begin
      pwr_reg <= pwr_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      shift_reg <= shift_next;
      byte_reg <= byte_next;
      frame_reg <= frame_next;
      ack_reg <= ack_next;
      bval_reg <= bval_next;
      lfsr_reg <= lfsr_next;
      rsp_v_reg <= rsp_v_next;
      rsp_f_reg <= rsp_f_next;
      rsp_d_reg <= rsp_d_next;
      wait_reg <= wait_next;
    end
  end

  hsac_sha1 u_sha1 (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_start(sha_start),
    .i_block(block),
    .o_busy(sha_busy),
    .o_done(sha_done),
    .o_digest(sha_digest)
  );

  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = !ack_reg;
  assign o_scl_out = 1'b0;
  assign o_scl_oe_n = 1'b1; // R12
  assign o_bus_byte = byte_reg;
  assign o_bus_byte_valid = bval_reg;
  assign o_cmd_ready = bus_open && !wait_reg && !sha_busy; // R5 R13
  assign o_rsp_valid = rsp_v_reg;
  assign o_rsp_flag = rsp_f_reg;
  assign o_rsp_data = rsp_d_reg;
  assign o_accepting = bus_open;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  sequence derive_taken;
    take && i_cmd_op == OP_DERIVE;
  endsequence
  sequence digest_out;
    ##82 (o_rsp_valid && o_rsp_data == sha_digest);
  endsequence

  scl_never_held_a: assert property (o_scl_oe_n) // R12
    else $error("clock line driven");
  sleep_no_ack_a: assert property ($past(sleep_s) |-> o_sda_oe_n) // R7
    else $error("data line driven while asleep");
  wake_hold_a: assert property ( // R8
    (pwr_reg == ST_WAKE && pwr_next == ST_READY) |->
    cnt_reg == WAKE_CYC - 1)
    else $error("wake hold length wrong");
  boot_hold_a: assert property ( // R5
    (pwr_reg == ST_BOOT && pwr_next == ST_READY) |->
    cnt_reg == boot_limit - 1)
    else $error("boot hold length wrong");
  cmd_gate_a: assert property (o_cmd_ready |-> pwr_reg == ST_READY) // R13
    else $error("command taken before ready");
  derive_latency_a: assert property (derive_taken |-> digest_out) // R3
    else $error("derived secret late or wrong");
  pad_block_a: assert property (sha_start |-> // R1
    block[319:312] == PAD_MARK && block[63:0] == MSG_LEN_BITS)
    else $error("block padding wrong");
  one_block_a: assert property (sha_start |-> !sha_busy) // R2
    else $error("second block fed to busy hash");
  challenge_a: assert property ( // R4
    (take && i_cmd_op == OP_CHALLENGE) |=>
    o_rsp_valid && o_rsp_data[63:0] == $past(lfsr_reg))
    else $error("challenge not from random source");
  ctr_up_a: assert property (ctr_we |-> // R11
    ctr_new <= CTR_MAX && ctr_new >= ctr_old)
    else $error("counter left its range");
  key_store_a: assert property ((take && i_cmd_op == OP_SET_KEY) |=> // R9
    key_mem[$past(i_cmd_index)] == $past(i_cmd_data))
    else $error("host key not stored");
  reset_state_a: assert property (@(posedge i_ref_clk) // R6
    $rose(i_resetn) |-> pwr_reg == ST_BOOT && !o_rsp_valid)
    else $error("state not cleared by reset");
endmodule : hsac_top

// >>> logic/hsac_pkg.sv
package hsac_pkg;
  localparam int CLK_KHZ = 200000;
  localparam int BOOT_READY_MS = 60;
  localparam int WAKE_HOLD_MS = 50;
  localparam int PENALTY_READY_MS = 1000;
  localparam int BOOT_READY_CYC = BOOT_READY_MS * CLK_KHZ;
  localparam int WAKE_HOLD_CYC = WAKE_HOLD_MS * CLK_KHZ;
  localparam int PENALTY_READY_CYC = PENALTY_READY_MS * CLK_KHZ;
  localparam int BLOCK_BITS = 512;
  localparam int FIELD_BITS = 64;
  localparam int DIGEST_BITS = 160;
  localparam int KEY_COUNT = 16;
  localparam int SECRET_COUNT = 4;
  localparam int PWD_SETS = 8;
  localparam int PWD_BITS = 24;
  localparam int CTR_COUNT = 4;
  localparam int CTR_BITS = 23;
  localparam logic [22:0] CTR_MAX = 23'h61A800;
  localparam logic [7:0] PAD_MARK = 8'h80;
  localparam logic [63:0] MSG_LEN_BITS = 64'h00000000000000C0;
  localparam logic [63:0] LFSR_SEED = 64'h5A5A_C3C3_0F0F_9669;
  localparam logic [6:0] LAST_ROUND = 7'h4F;
  localparam logic [159:0] SHA_INIT =
    160'h67452301_EFCDAB89_98BADCFE_10325476_C3D2E1F0;
  localparam logic [31:0] SHA_K0 = 32'h5A827999;
  localparam logic [31:0] SHA_K1 = 32'h6ED9EBA1;
  localparam logic [31:0] SHA_K2 = 32'h8F1BBCDC;
  localparam logic [31:0] SHA_K3 = 32'hCA62C1D6;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_SET_KEY = 3'h1,
    OP_SET_SECRET = 3'h2,
    OP_DERIVE = 3'h3,
    OP_CHALLENGE = 3'h4,
    OP_SET_PWD = 3'h5,
    OP_CHECK_PWD = 3'h6,
    OP_COUNT = 3'h7
  } hsac_op_t;

  typedef enum logic [3:0] {
    ST_BOOT = 4'h1,
    ST_WAKE = 4'h2,
    ST_SLEEP = 4'h4,
    ST_READY = 4'h8
  } hsac_pwr_t;
endpackage : hsac_pkg

// >>> logic/hsac_sha1.sv
`timescale 1ns/1ps
module hsac_sha1 import hsac_pkg::*; (
  // Clock and reset.
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // One padded block in, digest out.
  input wire logic i_start,
  input wire logic [BLOCK_BITS-1:0] i_block,
  output logic o_busy,
  output logic o_done,
  output logic [DIGEST_BITS-1:0] o_digest
);
  logic [15:0][31:0] w_reg, w_next;
  logic [159:0] st_reg, st_next;
  logic [159:0] dig_reg, dig_next;
  logic [6:0] round_reg, round_next;
  logic busy_reg, busy_next, done_reg, done_next;

  function automatic logic [31:0] rol(input logic [31:0] v, input int n);
    rol = (v << n) | (v >> (32 - n));
  endfunction : rol

  always_comb
  begin
    logic [31:0] a, b, c, d, e, f, k, t;
    a = st_reg[159:128];
    b = st_reg[127:96];
    c = st_reg[95:64];
    d = st_reg[63:32];
    e = st_reg[31:0];
    f = 32'h0;
    k = 32'h0;
    t = 32'h0;
    w_next = w_reg;
    st_next = st_reg;
    dig_next = dig_reg;
    round_next = round_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (round_reg < 7'h14)
    begin
      f = (b & c) | (~b & d);
      k = SHA_K0;
    end
    else if (round_reg < 7'h28)
    begin
      f = b ^ c ^ d;
      k = SHA_K1;
    end
    else if (round_reg < 7'h3C)
    begin
      f = (b & c) | (b & d) | (c & d);
      k = SHA_K2;
    end
    else
    begin
      f = b ^ c ^ d;
      k = SHA_K3;
    end
    t = rol(a, 5) + f + e + k + w_reg[0];
    // Exactly one compression round set per request; no chaining. (R2)
    if (!busy_reg && i_start)
    begin
      for (int i = 0; i < 16; i++)
        w_next[i] = i_block[BLOCK_BITS-1-32*i -: 32];
      st_next = SHA_INIT;
      round_next = 7'h00;
      busy_next = 1'b1;
    end
    else if (busy_reg)
    begin
      w_next = {rol(w_reg[13] ^ w_reg[8] ^ w_reg[2] ^ w_reg[0], 1),
        w_reg[15:1]};
      st_next = {t, a, rol(b, 30), c, d};
      round_next = round_reg + 7'h01;
      if (round_reg == LAST_ROUND)
      begin
        busy_next = 1'b0;
        done_next = 1'b1;
        for (int j = 0; j < 5; j++)
          dig_next[32*j +: 32] = SHA_INIT[32*j +: 32] + st_next[32*j +: 32];
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      w_reg <= '0;
      st_reg <= '0;
      dig_reg <= '0;
      round_reg <= 7'h00;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      w_reg <= w_next;
      st_reg <= st_next;
      dig_reg <= dig_next;
      round_reg <= round_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign o_busy = busy_reg;
  assign o_done = done_reg;
  assign o_digest = dig_reg;

  single_block_a: assert property (@(posedge i_ref_clk) // R2
    disable iff (!i_resetn)
    (i_start && !busy_reg) |-> ##81 (done_reg && !busy_reg))
    else $error("digest not ready 81 cycles after one block");
endmodule : hsac_sha1

// >>> sim/hsac_host_model.sv
`timescale 1ns/1ps
module hsac_host_model (
  // Clock.
  input wire logic i_ref_clk,
  // Device side of the open-drain data line.
  input wire logic i_sda_oe_n,
  input wire logic i_sda_out,
  // Lines as the host drives them.
  output logic o_scl,
  output logic o_sda
);
  localparam int HALF = 8;
  logic sda_drv_n = 1'b1;

  initial o_scl = 1'b1;
  // The data line has a pull-up, so it only reads low while a party pulls it.
  assign o_sda = sda_drv_n & (i_sda_oe_n | i_sda_out);

  task automatic half();
    repeat (HALF) @(posedge i_ref_clk);
  endtask : half

  // One whole frame: start, eight bits, acknowledge slot, stop.
  task automatic send_byte(input logic [7:0] b, output logic ack);
    sda_drv_n <= 1'b0;
    half();
    o_scl <= 1'b0;
    half();
    for (int i = 7; i >= 0; i--)
    begin
      sda_drv_n <= b[i];
      half();
      o_scl <= 1'b1;
      half();
      o_scl <= 1'b0;
      half();
    end
    sda_drv_n <= 1'b1;
    half();
    o_scl <= 1'b1;
    half();
    ack = (o_sda === 1'b0);
    o_scl <= 1'b0;
    half();
    sda_drv_n <= 1'b0;
    half();
    o_scl <= 1'b1;
    half();
    sda_drv_n <= 1'b1;
    half();
  endtask : send_byte
endmodule : hsac_host_model

// >>> sim/hsac_top_tb.sv
`timescale 1ns/1ps
module hsac_top_tb import hsac_pkg::*;;
  localparam int BOOT = 20;
  localparam int WAKE = 40;
  localparam int PEN = 60;
  logic ref_clk, resetn, supply, penalty, sleep, cmd_valid;
  logic [2:0] cmd_op;
  logic [3:0] cmd_index;
  logic [63:0] cmd_data, cmd_id, cmd_div, tag_id, tag_div;
  logic o_sda_out, o_sda_oe_n, o_scl_out, o_scl_oe_n, o_bus_byte_valid;
  logic o_cmd_ready, o_rsp_valid, o_rsp_flag, o_accepting;
  logic [7:0] o_bus_byte, last_byte;
  logic [159:0] o_rsp_data;
  logic host_scl, scl, sda;
  int bad_count = 0;
  int comparisons = 0;
  int bytes_seen = 0;
  int scl_held = 0;

  assign scl = host_scl & (o_scl_oe_n | o_scl_out);

  hsac_top #(.BOOT_CYC(BOOT), .WAKE_CYC(WAKE), .PENALTY_CYC(PEN)) u_dut (
    .i_ref_clk(ref_clk), .i_resetn(resetn), .i_supply_good(supply),
    .i_penalty_active(penalty), .i_sleep_request_pin(sleep),
    .i_scl(scl), .i_sda(sda), .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n), .o_scl_out(o_scl_out),
    .o_scl_oe_n(o_scl_oe_n), .o_bus_byte(o_bus_byte),
    .o_bus_byte_valid(o_bus_byte_valid), .i_cmd_valid(cmd_valid),
    .i_cmd_op(cmd_op), .i_cmd_index(cmd_index), .i_cmd_data(cmd_data),
    .i_cmd_id(cmd_id), .i_cmd_div(cmd_div), .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_flag(o_rsp_flag),
    .o_rsp_data(o_rsp_data), .o_accepting(o_accepting));

  hsac_host_model u_host (.i_ref_clk(ref_clk), .i_sda_oe_n(o_sda_oe_n),
    .i_sda_out(o_sda_out), .o_scl(host_scl), .o_sda(sda));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk)
  begin
    if (o_bus_byte_valid === 1'b1)
    begin
      bytes_seen++;
      last_byte = o_bus_byte;
    end
    if (resetn === 1'b1 && o_scl_oe_n !== 1'b1)
      scl_held++;
  end

  task automatic test_done();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  task automatic check_bit(input string what, input logic exp,
                           input logic got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : check_bit

  task automatic check_vec(input string what, input logic [159:0] exp,
                           input logic [159:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check_vec

  // Reference digest of one padded block, kept apart from the design.
  function automatic logic [159:0] sha1(input logic [511:0] m);
    logic [31:0] w [0:79];
    logic [31:0] a, b, c, d, e, f, k, t;
    for (int i = 0; i < 16; i++)
      w[i] = m[511-32*i -: 32];
    for (int i = 16; i < 80; i++)
    begin
      t = w[i-3] ^ w[i-8] ^ w[i-14] ^ w[i-16];
      w[i] = {t[30:0], t[31]};
    end
    {a, b, c, d, e} = SHA_INIT;
    for (int i = 0; i < 80; i++)
    begin
      f = (i < 20) ? ((b & c) | (~b & d)) : (i < 40 || i >= 60) ?
          (b ^ c ^ d) : ((b & c) | (b & d) | (c & d));
      k = (i < 20) ? SHA_K0 : (i < 40) ? SHA_K1 : (i < 60) ? SHA_K2 : SHA_K3;
      t = {a[26:0], a[31:27]} + f + e + k + w[i];
      e = d;
      d = c;
      c = {b[1:0], b[31:2]};
      b = a;
      a = t;
    end
    return {SHA_INIT[159:128] + a, SHA_INIT[127:96] + b,
            SHA_INIT[95:64] + c, SHA_INIT[63:32] + d, SHA_INIT[31:0] + e};
  endfunction : sha1

  // Issues one command and checks that its answer comes exactly lat later.
  task automatic do_cmd(input logic [2:0] op, input logic [3:0] idx,
                        input logic [63:0] d, input int lat);
    int n;
    n = 0;
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_index <= idx;
    cmd_data <= d;
    cmd_id <= tag_id;
    cmd_div <= tag_div;
    @(negedge ref_clk);
    while (o_cmd_ready !== 1'b1 && n < 200)
    begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    repeat (lat - 1)
    begin
      @(negedge ref_clk);
      check_bit("rsp early", 1'b0, o_rsp_valid);
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    check_bit("rsp valid", 1'b1, o_rsp_valid);
  endtask : do_cmd

  task automatic wait_acc(output int n);
    n = 0;
    while (o_accepting !== 1'b1 && n < 400)
    begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_acc

  task automatic t_boot();
    int n;
    repeat (30) @(negedge ref_clk);
    check_bit("no supply", 1'b0, o_accepting);
    @(posedge ref_clk);
    penalty <= 1'b1;
    supply <= 1'b1;
    wait_acc(n);
    check_bit("penalty span", 1'b1, n >= PEN && n <= PEN + 4);
    @(posedge ref_clk);
    penalty <= 1'b0;
  endtask : t_boot

  task automatic t_store();
    logic [63:0] c0;
    do_cmd(3'h0, 4'h0, 64'h0, 1);
    do_cmd(3'h1, 4'hF, 64'hFEDC_BA98_7654_3210, 1);
    check_vec("key rsp", 160'h0, o_rsp_data);
    do_cmd(3'h5, 4'hF, 64'h0000_0000_00AB_CDEF, 1);
    do_cmd(3'h5, 4'h7, 64'h0000_0000_0012_3456, 1);
    do_cmd(3'h6, 4'hF, 64'hFFFF_FFFF_FFAB_CDEF, 1);
    check_bit("pwd match", 1'b1, o_rsp_flag);
    do_cmd(3'h6, 4'h7, 64'h0000_0000_00AB_CDEF, 1);
    check_bit("pwd other", 1'b0, o_rsp_flag);
    do_cmd(3'h4, 4'h0, 64'h0, 1);
    c0 = o_rsp_data[63:0];
    do_cmd(3'h4, 4'h0, 64'h0, 1);
    check_bit("new chal", 1'b1, o_rsp_data[63:0] !== c0);
    do_cmd(3'h7, 4'h3, 64'h0, 1);
    c0 = {41'h0, o_rsp_data[22:0]};
    do_cmd(3'h7, 4'h3, 64'h0, 1);
    check_vec("count", {137'h0, c0[22:0] + 23'h1}, o_rsp_data);
  endtask : t_store

  task automatic t_derive();
    logic [63:0] sec;
    for (int s = 0; s < 4; s++)
    begin
      sec = 64'h0123_4567_89AB_CDEF ^ {16{s[3:0]}};
      tag_id = 64'h1122_3344_5566_7788 + 64'(s);
      tag_div = 64'hA0B1_C2D3_E4F5_0617 - 64'(s);
      do_cmd(3'h2, 4'(s), sec, 1);
      do_cmd(3'h3, 4'(s), 64'h0, 82);
      check_vec("digest", sha1({sec, tag_id, tag_div, PAD_MARK, 248'h0,
        MSG_LEN_BITS}), o_rsp_data);
    end
  endtask : t_derive

  task automatic t_bus();
    logic ack;
    int seen;
    @(posedge ref_clk);
    sleep <= 1'b1;
    repeat (6) @(posedge ref_clk);
    seen = bytes_seen;
    u_host.send_byte(8'h3C, ack);
    check_bit("ack asleep", 1'b0, ack);
    sleep <= 1'b0;
    repeat (4) @(posedge ref_clk);
    u_host.send_byte(8'h5A, ack);
    check_bit("ack waking", 1'b0, ack);
    check_bit("bytes ignored", 1'b1, bytes_seen == seen);
    repeat (WAKE + 10) @(posedge ref_clk);
    u_host.send_byte(8'hA5, ack);
    check_bit("ack awake", 1'b1, ack);
    check_bit("byte taken", 1'b1, bytes_seen == seen + 1);
    check_vec("bus byte", 160'h0A5, {152'h0, last_byte});
    check_bit("clock free", 1'b1, scl_held == 0);
  endtask : t_bus

  task automatic t_reset_sleep();
    int n;
    @(posedge ref_clk);
    sleep <= 1'b1;
    resetn <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check_bit("rst accepting", 1'b0, o_accepting);
    check_bit("rst ready", 1'b0, o_cmd_ready);
    check_bit("rst sda", 1'b1, o_sda_oe_n);
    check_bit("rst rsp", 1'b0, o_rsp_valid);
    @(posedge ref_clk);
    sleep <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    wait_acc(n);
    check_bit("boot span", 1'b1, n >= BOOT && n <= BOOT + 4);
    do_cmd(3'h0, 4'h0, 64'h0, 1);
  endtask : t_reset_sleep

  initial
  begin
    {resetn, supply, penalty, sleep, cmd_valid} = 5'h00;
    {cmd_op, cmd_index} = 7'h00;
    {cmd_data, cmd_id, cmd_div, tag_id, tag_div} = 320'h0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    t_boot();
    t_store();
    t_derive();
    t_bus();
    t_reset_sleep();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    test_done();
  end
endmodule : hsac_top_tb
